//--- core/compare_decimal_op_decoder.sv
// decode and timing of the compare and decimal-add instruction group
// assumes the fetch unit presents one opcode at a time, synchronous to clock
//
// Function
// - short compare immediate: 2-bit dest 00/10/11/01, costs 2/1, 3/3, 4/3
// - prefix 00001001 marks indirect destination: one more byte, three cycles
// - size bit 1 is word; widens short and decimal immediates by one byte
// - general compare prefix 01000001 marks indirect source only
// - general compare prefix 01001001 marks both operands indirect
// - one indirect operand adds 1 byte/3 cycles, two add 1/6
// - 5-bit field register modes: data registers, address registers, indirect
// - 5-bit field memory modes: 8/16/24-bit displacements and absolutes
// - byte/word compare costs 1, 3 or 4 cycles; 2 bytes plus extensions
// - long compare takes only the two register pairs among data registers; 2, 5 or 8 cycles
// - short compare into first data register: 2/3 displacement, 3/3 absolute
// - extended-immediate compare: long destination, 3 bytes, 2 or 4 cycles
// - decimal add-carry immediate: 4 bytes, 4 or 6 cycles
// - decimal add-carry two operands: 3 bytes, 4, 6 or 7 cycles
// - decimal add two operands times like add-carry: 4, 6 or 7
`timescale 1ns/10ps
`default_nettype none
module compare_decimal_op_decoder
	import compare_decimal_pkg::*;
(
	input  wire logic                               clock,
	input  wire logic                               reset_n,
	input  wire logic                               op_valid,
	output logic                                    op_ready,
	input  wire compare_decimal_pkg::op_form_t      op_form,
	input  wire logic                               prefix_valid,
	input  wire logic [7:0]                         prefix_byte,
	input  wire logic                               size_word,
	input  wire logic [4:0]                         src_field,
	input  wire logic [4:0]                         dst_field,
	input  wire logic [1:0]                         short_field,
	output logic                                    decode_valid,
	output logic                                    decode_illegal,
	output logic [3:0]                              instr_length,
	output logic [3:0]                              exec_cycles,
	output logic [1:0]                              src_ext_bytes,
	output logic [1:0]                              dst_ext_bytes,
	output compare_decimal_pkg::operand_kind_t      src_kind,
	output compare_decimal_pkg::operand_kind_t      dst_kind,
	output logic                                    src_indirect,
	output logic                                    dst_indirect,
	output logic                                    writes_dest,
	output logic                                    exec_busy,
	output logic                                    exec_done
);
	import compare_decimal_pkg::*;

	// -----------------------------------------------
	// operand field decoding
	// -----------------------------------------------
	function automatic operand_kind_t kind_of(input logic [4:0] f, input logic long_op);
		operand_kind_t k;
		k = kind_bad;
		if (f[4:2] == MODE_DATA) begin
			// long forms only name the two register pairs
			k = (!long_op || f == PAIR_FIRST || f == PAIR_SECOND) ? kind_data_reg : kind_bad;
		end else if (f[4:1] == MODE_ADDR) begin
			k = kind_addr_reg;
		end else if (f[4:1] == MODE_IND) begin
			k = kind_addr_ind;
		end else if (f == MODE_ABSOLUTE_16BIT_MODE || f == MODE_ABSOLUTE_24BIT_MODE) begin
			k = kind_abs;
		end else if (f[4] == 1'b0) begin
			k = kind_disp;
		end
		return k;
	endfunction

	function automatic logic [1:0] ext_of(input logic [4:0] f);
		logic [1:0] e;
		e = 2'h0;
		if (f[4:2] == MODE_DSP8) begin
			e = EXT_DSP8;
		end else if (f[4:2] == MODE_DSP16 || f == MODE_ABSOLUTE_16BIT_MODE) begin
			e = EXT_16;
		end else if (f[4:1] == MODE_DSP24 || f == MODE_ABSOLUTE_24BIT_MODE) begin
			e = EXT_24;
		end
		return e;
	endfunction

	function automatic logic is_mem(input operand_kind_t k);
		return k == kind_addr_ind || k == kind_disp || k == kind_abs;
	endfunction

	// -----------------------------------------------
	// combinational decode of the offered opcode
	// -----------------------------------------------
	exec_state_t   state;
	logic [3:0]    count;
	logic          take;
	logic          long_op;
	logic          next_bad;
	logic [3:0]    next_len;
	logic [3:0]    next_cyc;
	logic [1:0]    next_se;
	logic [1:0]    next_de;
	logic          next_si;
	logic          next_di;
	operand_kind_t next_sk;
	operand_kind_t next_dk;
	logic [1:0]    n_mem;
	logic          decimal_op;

	assign op_ready   = (state == st_idle);
	assign take       = op_valid && op_ready;
	assign long_op    = (op_form == form_cmp_long) || (op_form == form_cmp_ext_imm);
	assign decimal_op = (op_form == form_decimal_add_with_carry_op_imm) || (op_form == form_decimal_add_with_carry_op) || (op_form == form_decimal_add_op);

	always_comb begin
		next_bad = 1'b0;
		next_si  = 1'b0;
		next_di  = 1'b0;
		next_sk  = kind_of(src_field, long_op);
		next_dk  = kind_of(dst_field, long_op);
		next_se  = ext_of(src_field);
		next_de  = ext_of(dst_field);
		next_len = LEN_GENERAL;
		next_cyc = CYC_GEN_REG;
		if (prefix_valid) begin
			case (prefix_byte)
				PREFIX_DST: next_di = 1'b1;
				PREFIX_SRC: next_si = 1'b1;
				PREFIX_BOTH: begin
					next_si = 1'b1;
					next_di = 1'b1;
				end
				default: next_bad = 1'b1;
			endcase
		end
		n_mem = {1'b0, is_mem(next_sk)} + {1'b0, is_mem(next_dk)};
		case (op_form)
			form_cmp_short_imm, form_cmp_short_src: begin
				// short forms carry a 2-bit field; the data register is implied
				next_sk = kind_data_reg;
				next_dk = kind_data_reg;
				next_se = 2'h0;
				next_de = 2'h0;
				next_cyc = CYC_SHORT_MEM;
				case (short_field)
					SHORT_DATA: begin
						next_len = LEN_SHORT_REG;
						next_cyc = CYC_SHORT_REG;
						next_bad = next_bad || (op_form == form_cmp_short_src);
					end
					SHORT_ABSOLUTE_16BIT_MODE: begin
						next_dk  = kind_abs;
						next_de  = EXT_16;
						next_len = (op_form == form_cmp_short_src) ? LEN_SRC_ABS : LEN_SHORT_ABS;
					end
					default: begin
						next_dk  = kind_disp;
						next_de  = EXT_DSP8;
						next_len = (op_form == form_cmp_short_src) ? LEN_SRC_DSP : LEN_SHORT_DSP;
					end
				endcase
				if (op_form == form_cmp_short_imm) begin
					next_len = next_len + (size_word ? LEN_WORD_IMM : 4'h0);
				end else begin
					// the source form puts its memory operand on the source side
					next_sk = next_dk;
					next_se = next_de;
					next_dk = kind_data_reg;
					next_de = 2'h0;
					next_si = next_di;
					next_di = 1'b0;
				end
				next_bad = next_bad || (prefix_valid && prefix_byte != PREFIX_DST);
			end
			form_cmp_general, form_cmp_long, form_decimal_add_with_carry_op, form_decimal_add_op: begin
				next_len = ((op_form == form_decimal_add_with_carry_op) || (op_form == form_decimal_add_op)) ? LEN_DECIMAL : LEN_GENERAL;
				next_len = next_len + 4'(next_se) + 4'(next_de);
				case (op_form)
					form_cmp_general: next_cyc = (n_mem == 2'd0) ? CYC_GEN_REG :
						(n_mem == 2'd1) ? CYC_GEN_ONE : CYC_GEN_TWO;
					form_cmp_long: next_cyc = (n_mem == 2'd0) ? CYC_LONG_REG :
						(n_mem == 2'd1) ? CYC_LONG_ONE : CYC_LONG_TWO;
					default: next_cyc = (n_mem == 2'd0) ? CYC_DEC_REG :
						(n_mem == 2'd1) ? CYC_DEC_ONE : CYC_DEC_TWO;
				endcase
				// decimal adds have no indirect prefix
				next_bad = next_bad || (prefix_valid && decimal_op) ||
					next_sk == kind_bad || next_dk == kind_bad;
			end
			default: begin
				// immediate forms: only a destination field
				next_sk = kind_data_reg;
				next_se = 2'h0;
				if (op_form == form_cmp_ext_imm) begin
					next_len = LEN_EXT_IMM + 4'(next_de);
					next_cyc = is_mem(next_dk) ? CYC_EXT_MEM : CYC_EXT_REG;
				end else begin
					next_len = LEN_DECIMAL_ADD_WITH_CARRY_OP_IMM + 4'(next_de) + (size_word ? LEN_WORD_IMM : 4'h0);
					next_cyc = is_mem(next_dk) ? CYC_DEC_ONE : CYC_DEC_REG;
				end
				next_bad = next_bad || next_dk == kind_bad ||
					(prefix_valid && (decimal_op || prefix_byte != PREFIX_DST));
			end
		endcase
		if (next_si || next_di) begin
			next_len = next_len + LEN_PREFIX;
			next_cyc = next_cyc + ((next_si && next_di) ? CYC_IND_TWO : CYC_IND_ONE);
		end
	end

	// -----------------------------------------------
	// registered decode results
	// -----------------------------------------------
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			decode_valid   <= 1'b0;
			decode_illegal <= 1'b0;
		end else begin
			decode_valid   <= take;
			decode_illegal <= take ? next_bad : decode_illegal;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			instr_length  <= 4'h0;
			exec_cycles   <= 4'h0;
			src_ext_bytes <= 2'h0;
			dst_ext_bytes <= 2'h0;
			src_kind      <= kind_data_reg;
			dst_kind      <= kind_data_reg;
			src_indirect  <= 1'b0;
			dst_indirect  <= 1'b0;
			writes_dest   <= 1'b0;
		end else if (take) begin
			instr_length  <= next_len;
			exec_cycles   <= next_cyc;
			src_ext_bytes <= next_se;
			dst_ext_bytes <= next_de;
			src_kind      <= next_sk;
			dst_kind      <= next_dk;
			src_indirect  <= next_si;
			dst_indirect  <= next_di;
			writes_dest   <= decimal_op && !next_bad;
		end
	end

	// -----------------------------------------------
	// execution timing
	// -----------------------------------------------
	// an illegal opcode never enters execution, so the pipeline can trap at once
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state <= st_idle;
			count <= 4'h0;
		end else begin
			case (state)
				st_idle: begin
					if (take && !next_bad) begin
						state <= st_exec;
						count <= next_cyc;
					end
				end
				st_exec: begin
					count <= count - 4'h1;
					if (count == COUNT_LAST) begin
						state <= st_done;
					end
				end
				st_done: state <= st_idle;
				default: state <= st_idle;
			endcase
		end
	end

	assign exec_busy = (state == st_exec);
	assign exec_done = (state == st_done);

	// -----------------------------------------------
	// checks
	// -----------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	sequence s_take_plain(op_form_t f);
		take && op_form == f && !prefix_valid;
	endsequence

	sequence s_take_pref(op_form_t f, logic [7:0] p);
		take && op_form == f && prefix_valid && prefix_byte == p;
	endsequence

	a_short_imm_cost: assert property (s_take_plain(form_cmp_short_imm) and (short_field == SHORT_DATA && !size_word)
		|=> instr_length == 4'h2 && exec_cycles == 4'h1 && !decode_illegal) else $error("short compare cost wrong");
	a_dest_prefix_cost: assert property (s_take_pref(form_cmp_ext_imm, PREFIX_DST) and (dst_field == PAIR_FIRST)
		|=> dst_indirect && instr_length == 4'h4 && exec_cycles == 4'h5) else $error("indirect dest cost wrong");
	a_word_imm_len: assert property (s_take_plain(form_decimal_add_with_carry_op_imm) and (size_word && dst_field == PAIR_FIRST)
		|=> instr_length == 4'h5 && exec_cycles == 4'h4) else $error("word immediate length wrong");
	a_src_prefix: assert property (s_take_pref(form_cmp_general, PREFIX_SRC)
		|=> src_indirect && !dst_indirect) else $error("source prefix misread");
	a_both_prefix: assert property (s_take_pref(form_cmp_general, PREFIX_BOTH) and (src_field == PAIR_FIRST && dst_field == PAIR_SECOND)
		|=> src_indirect && dst_indirect && instr_length == 4'h3 && exec_cycles == 4'h7) else $error("double indirect cost wrong");
	a_addr_reg_kind: assert property (take && dst_field == 5'h02 && op_form == form_cmp_general
		|=> dst_kind == kind_addr_reg) else $error("address register not decoded");
	a_general_mem: assert property (s_take_plain(form_cmp_general) and (src_field == 5'h04 && dst_field == MODE_ABSOLUTE_24BIT_MODE)
		|=> instr_length == 4'h6 && exec_cycles == 4'h4 && src_ext_bytes == 2'h1 && dst_ext_bytes == 2'h3) else $error("general cost wrong");
	a_long_reject: assert property (take && op_form == form_cmp_long && src_field == 5'h10
		|=> decode_valid && decode_illegal && !exec_busy && op_ready) else $error("long form took a byte register");
	a_short_src_abs: assert property (s_take_plain(form_cmp_short_src) and (short_field == SHORT_ABSOLUTE_16BIT_MODE)
		|=> instr_length == 4'h3 && exec_cycles == 4'h3) else $error("short source cost wrong");
	a_decimal_add_with_carry_op_two_mem: assert property (s_take_plain(form_decimal_add_with_carry_op) and (src_field == 5'h00 && dst_field == MODE_ABSOLUTE_16BIT_MODE)
		|=> instr_length == 4'h5 && exec_cycles == 4'h7) else $error("decimal add-carry cost wrong");
	a_decimal_add_op_span: assert property (s_take_plain(form_decimal_add_op) and (src_field == PAIR_FIRST && dst_field == PAIR_SECOND)
		|=> exec_busy [*4] ##1 exec_done ##1 op_ready) else $error("decimal add timing wrong");
	a_write_back: assert property (decode_valid && !decode_illegal |-> writes_dest == $past(decimal_op))
		else $error("write-back flag wrong");
endmodule
`default_nettype wire

//--- core/compare_decimal_pkg.sv
// constants and types for the compare / decimal-add decoder
// assumes one core clock; no software-visible registers
package compare_decimal_pkg;
	typedef enum logic [2:0] {
		form_cmp_short_imm = 3'h0,
		form_cmp_general   = 3'h1,
		form_cmp_long      = 3'h2,
		form_cmp_short_src = 3'h3,
		form_cmp_ext_imm   = 3'h4,
		form_decimal_add_with_carry_op_imm      = 3'h5,
		form_decimal_add_with_carry_op          = 3'h6,
		form_decimal_add_op          = 3'h7
	} op_form_t;
	typedef enum logic [2:0] {
		kind_data_reg = 3'h0,
		kind_addr_reg = 3'h1,
		kind_addr_ind = 3'h2,
		kind_disp     = 3'h3,
		kind_abs      = 3'h4,
		kind_bad      = 3'h5
	} operand_kind_t;
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_exec = 2'b01,
		st_done = 2'b11
	} exec_state_t;
	// -----------------------------------------------
	// prefix bytes and operand field codes
	// -----------------------------------------------
	localparam logic [7:0] PREFIX_DST    = 8'h09;
	localparam logic [7:0] PREFIX_SRC    = 8'h41;
	localparam logic [7:0] PREFIX_BOTH   = 8'h49;
	localparam logic [2:0] MODE_DATA     = 3'h4;
	localparam logic [3:0] MODE_ADDR     = 4'h1;
	localparam logic [3:0] MODE_IND      = 4'h0;
	localparam logic [2:0] MODE_DSP8     = 3'h1;
	localparam logic [2:0] MODE_DSP16    = 3'h2;
	localparam logic [3:0] MODE_DSP24    = 4'h6;
	localparam logic [4:0] MODE_ABSOLUTE_16BIT_MODE    = 5'h0f;
	localparam logic [4:0] MODE_ABSOLUTE_24BIT_MODE    = 5'h0e;
	localparam logic [4:0] PAIR_FIRST    = 5'h12;
	localparam logic [4:0] PAIR_SECOND   = 5'h13;
	localparam logic [1:0] SHORT_DATA    = 2'b00;
	localparam logic [1:0] SHORT_ABSOLUTE_16BIT_MODE   = 2'b01;
	localparam logic [1:0] EXT_DSP8      = 2'h1;
	localparam logic [1:0] EXT_16        = 2'h2;
	localparam logic [1:0] EXT_24        = 2'h3;
	// -----------------------------------------------
	// lengths in bytes and execution cycles
	// -----------------------------------------------
	localparam logic [3:0] LEN_SHORT_REG = 4'h2;
	localparam logic [3:0] LEN_SHORT_DSP = 4'h3;
	localparam logic [3:0] LEN_SHORT_ABS = 4'h4;
	localparam logic [3:0] LEN_SRC_DSP   = 4'h2;
	localparam logic [3:0] LEN_SRC_ABS   = 4'h3;
	localparam logic [3:0] LEN_GENERAL   = 4'h2;
	localparam logic [3:0] LEN_EXT_IMM   = 4'h3;
	localparam logic [3:0] LEN_DECIMAL_ADD_WITH_CARRY_OP_IMM  = 4'h4;
	localparam logic [3:0] LEN_DECIMAL   = 4'h3;
	localparam logic [3:0] LEN_PREFIX    = 4'h1;
	localparam logic [3:0] LEN_WORD_IMM  = 4'h1;
	localparam logic [3:0] CYC_SHORT_REG = 4'h1;
	localparam logic [3:0] CYC_SHORT_MEM = 4'h3;
	localparam logic [3:0] CYC_GEN_REG   = 4'h1;
	localparam logic [3:0] CYC_GEN_ONE   = 4'h3;
	localparam logic [3:0] CYC_GEN_TWO   = 4'h4;
	localparam logic [3:0] CYC_LONG_REG  = 4'h2;
	localparam logic [3:0] CYC_LONG_ONE  = 4'h5;
	localparam logic [3:0] CYC_LONG_TWO  = 4'h8;
	localparam logic [3:0] CYC_EXT_REG   = 4'h2;
	localparam logic [3:0] CYC_EXT_MEM   = 4'h4;
	localparam logic [3:0] CYC_DEC_REG   = 4'h4;
	localparam logic [3:0] CYC_DEC_ONE   = 4'h6;
	localparam logic [3:0] CYC_DEC_TWO   = 4'h7;
	localparam logic [3:0] CYC_IND_ONE   = 4'h3;
	localparam logic [3:0] CYC_IND_TWO   = 4'h6;
	localparam logic [3:0] COUNT_LAST    = 4'h1;
endpackage

//--- tb/fetch_pipe_model.sv
// fetch-side model: offers one opcode at a time to the decoder
// assumes offer/idle are called from one bench process; drives at falling edge
`timescale 1ns/10ps
`default_nettype none
module fetch_pipe_model
	import compare_decimal_pkg::*;
(
	input  wire logic                          clock,
	input  wire logic                          op_ready,
	output logic                               op_valid,
	output compare_decimal_pkg::op_form_t      op_form,
	output logic                               prefix_valid,
	output logic [7:0]                         prefix_byte,
	output logic                               size_word,
	output logic [4:0]                         src_field,
	output logic [4:0]                         dst_field,
	output logic [1:0]                         short_field
);
	logic rdy;
	initial begin
		{op_valid, prefix_valid, prefix_byte, size_word} = '0;
		{src_field, dst_field, short_field} = '0;
		op_form = form_cmp_short_imm;
	end
	// released fields are inverted on each wait cycle of offer and once by idle, so an early read shows junk after one inversion and the old value after two
	task automatic scramble();
		op_form = op_form_t'(~op_form);
		{prefix_valid, prefix_byte, size_word} = ~{prefix_valid, prefix_byte, size_word};
		{src_field, dst_field, short_field} = ~{src_field, dst_field, short_field};
	endtask
	task automatic idle();
		@(negedge clock);
		op_valid = 1'b0;
		scramble();
	endtask
	task automatic offer(input op_form_t f, input logic pv, input logic [7:0] pb, input logic sw,
			input logic [4:0] sf, input logic [4:0] df, input logic [1:0] sh, input int slow);
		@(negedge clock);
		repeat (slow) begin
			op_valid = 1'b0;
			scramble();
			@(negedge clock);
		end
		op_valid = 1'b1;
		op_form = f;
		{prefix_valid, prefix_byte} = {pv, pb}; // prefix with its opcode
		{size_word, src_field, dst_field, short_field} = {sw, sf, df, sh};
		rdy = 1'b0;
		// hold the offer until an edge that sees the decoder idle
		while (!rdy) begin
			rdy = (op_ready === 1'b1);
			@(posedge clock);
			if (!rdy) @(negedge clock);
		end
	endtask
endmodule
`default_nettype wire

//--- tb/compare_decimal_op_decoder_tb.sv
// self-checking bench for the compare / decimal-add decoder
// assumes the fetch model in fetch_pipe_model; expectations worked out here
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module compare_decimal_op_decoder_tb;
	import compare_decimal_pkg::*;
	typedef struct {
		logic ill, si, di, wr;
		logic [3:0] len, cyc;
		logic [1:0] se, de;
		operand_kind_t sk, dk;
		int k;
	} expect_t;
	logic clock, reset_n, op_valid, op_ready, prefix_valid, size_word, decode_valid, decode_illegal;
	logic src_indirect, dst_indirect, writes_dest, exec_busy, exec_done;
	logic [7:0] prefix_byte;
	logic [4:0] src_field, dst_field, n;
	logic [1:0] short_field, src_ext_bytes, dst_ext_bytes;
	logic [3:0] instr_length, exec_cycles;
	op_form_t op_form;
	operand_kind_t src_kind, dst_kind;
	expect_t exp_q[$];
	expect_t e;
	int error_cnt = 0;
	int n_compared = 0;
	initial clock = 1'b0;
	always #5 clock = ~clock;
	compare_decimal_op_decoder dut (.clock(clock), .reset_n(reset_n), .op_valid(op_valid), .op_ready(op_ready),
		.op_form(op_form), .prefix_valid(prefix_valid), .prefix_byte(prefix_byte), .size_word(size_word),
		.src_field(src_field), .dst_field(dst_field), .short_field(short_field), .decode_valid(decode_valid),
		.decode_illegal(decode_illegal), .instr_length(instr_length), .exec_cycles(exec_cycles),
		.src_ext_bytes(src_ext_bytes), .dst_ext_bytes(dst_ext_bytes), .src_kind(src_kind), .dst_kind(dst_kind),
		.src_indirect(src_indirect), .dst_indirect(dst_indirect), .writes_dest(writes_dest),
		.exec_busy(exec_busy), .exec_done(exec_done));
	fetch_pipe_model fetch (.clock(clock), .op_ready(op_ready), .op_valid(op_valid), .op_form(op_form),
		.prefix_valid(prefix_valid), .prefix_byte(prefix_byte), .size_word(size_word), .src_field(src_field),
		.dst_field(dst_field), .short_field(short_field));
	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h00000000);
	endfunction
	function automatic logic [1:0] ext_of(logic [4:0] f);
		casez (f)
			5'b001??: return 2'h1;
			5'b010??: return 2'h2;
			5'b0110?: return 2'h3;
			5'b0111?: return f[0] ? 2'h2 : 2'h3;
			default: return 2'h0;
		endcase
	endfunction
	function automatic operand_kind_t kind_of(logic [4:0] f);
		casez (f)
			5'b100??: return kind_data_reg;
			5'b0001?: return kind_addr_reg;
			5'b0000?: return kind_addr_ind;
			5'b001??, 5'b010??, 5'b0110?: return kind_disp;
			5'b0111?: return kind_abs;
			default: return kind_bad;
		endcase
	endfunction
	function automatic logic [3:0] is_mem(operand_kind_t k);
		return (k inside {kind_addr_ind, kind_disp, kind_abs}) ? 4'h1 : 4'h0;
	endfunction
	function automatic expect_t predict(op_form_t fm, logic pv, logic [7:0] pb, logic sw, logic [4:0] sf,
			logic [4:0] df, logic [1:0] sh);
		expect_t x;
		logic ill;
		logic [3:0] nm;
		x.si = pv && (pb == 8'h41 || pb == 8'h49);
		x.di = pv && (pb == 8'h09 || pb == 8'h49);
		ill = pv && !(x.si || x.di);
		x.sk = kind_of(sf);
		x.dk = kind_of(df);
		x.se = ext_of(sf);
		x.de = ext_of(df);
		nm = is_mem(x.dk);
		x.k = 1;
		if (fm inside {form_cmp_short_imm, form_cmp_short_src, form_cmp_ext_imm, form_decimal_add_with_carry_op_imm}) begin
			ill |= x.si;
		end else begin
			x.k = 2;
			nm += is_mem(x.sk);
			ill |= (x.sk == kind_bad);
		end
		case (fm)
			form_cmp_short_imm: begin
				x.k = 0;
				x.len = ((sh == 2'b00) ? 4'h2 : ((sh == 2'b01) ? 4'h4 : 4'h3)) + {3'h0, sw};
				x.cyc = (sh == 2'b00) ? 4'h1 : 4'h3;
			end
			form_cmp_short_src: begin
				x.k = 0;
				ill |= (sh == 2'b00);
				x.len = (sh == 2'b01) ? 4'h3 : 4'h2;
				x.cyc = 4'h3;
				x.si = x.di;
				x.di = 1'b0;
			end
			form_cmp_ext_imm: begin
				ill |= (df[4:1] == 4'b1000);
				x.len = 4'h3 + {2'h0, x.de};
				x.cyc = (nm != 0) ? 4'h4 : 4'h2;
			end
			form_decimal_add_with_carry_op_imm: begin
				ill |= pv;
				x.len = 4'h4 + {2'h0, x.de} + {3'h0, sw};
				x.cyc = (nm != 0) ? 4'h6 : 4'h4;
			end
			form_cmp_long: begin
				ill |= (sf[4:1] == 4'b1000) || (df[4:1] == 4'b1000);
				x.len = 4'h2 + {2'h0, x.se} + {2'h0, x.de};
				x.cyc = (nm == 0) ? 4'h2 : ((nm == 1) ? 4'h5 : 4'h8);
			end
			form_cmp_general: begin
				x.len = 4'h2 + {2'h0, x.se} + {2'h0, x.de};
				x.cyc = (nm == 0) ? 4'h1 : ((nm == 1) ? 4'h3 : 4'h4);
			end
			default: begin
				ill |= pv;
				x.len = 4'h3 + {2'h0, x.se} + {2'h0, x.de};
				x.cyc = (nm == 0) ? 4'h4 : ((nm == 1) ? 4'h6 : 4'h7);
			end
		endcase
		if (x.k > 0) ill |= (x.dk == kind_bad);
		if (x.si || x.di) begin
			x.len += 4'h1;
			x.cyc += (x.si && x.di) ? 4'h6 : 4'h3;
		end
		x.wr = !ill && (fm inside {form_decimal_add_with_carry_op_imm, form_decimal_add_with_carry_op, form_decimal_add_op});
		x.ill = ill;
		return x;
	endfunction
	// note the expectation first, then hand the opcode to the fetch model
	task automatic run(input op_form_t f, input logic pv, input logic [7:0] pb, input logic sw,
			input logic [4:0] sf, input logic [4:0] df, input logic [1:0] sh, input int slow);
		exp_q.push_back(predict(f, pv, pb, sw, sf, df, sh));
		fetch.offer(f, pv, pb, sw, sf, df, sh, slow);
	endtask
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ---------------------------------------------
	// result watcher: oldest note against each decode
	// ---------------------------------------------
	initial forever begin
		@(negedge clock);
		if (decode_valid === 1'b1) begin
			`CHK(exp_q.size() > 0, 1'b1)
			e = exp_q.pop_front();
			`CHK(decode_illegal, e.ill)
			`CHK(writes_dest, e.wr)
			if (!e.ill) begin
				`CHK(instr_length, e.len)
				`CHK(exec_cycles, e.cyc)
				`CHK({src_indirect, dst_indirect}, {e.si, e.di})
				if (e.k > 0) `CHK({dst_ext_bytes, dst_kind}, {e.de, e.dk})
				if (e.k > 1) `CHK({src_ext_bytes, src_kind}, {e.se, e.sk})
				n = 5'h0;
				while (exec_busy === 1'b1 && n < 5'h1f) begin
					n++;
					@(negedge clock);
				end
				`CHK(n, {1'b0, e.cyc})
				`CHK(exec_done, 1'b1)
			end
		end
	end
	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		logic [31:0] r;
		logic [4:0] sf, df;
		op_form_t f;
		logic [7:0] pb;
		r = 32'h00010c4b; // 68683
		reset_n = 1'b0;
		repeat (8) @(negedge clock);
		reset_n = 1'b1;
		@(negedge clock);
		`CHK({op_ready, decode_valid, exec_busy, instr_length}, {1'b1, 1'b0, 1'b0, 4'h0})
		// directed corners first: field pairs that random draws seldom hit
		run(form_decimal_add_op, 1'b0, 8'h00, 1'b0, 5'h12, 5'h13, 2'b00, 0);
		run(form_cmp_ext_imm, 1'b1, 8'h09, 1'b0, 5'h12, 5'h12, 2'b00, 0);
		run(form_decimal_add_with_carry_op_imm, 1'b0, 8'h00, 1'b1, 5'h12, 5'h12, 2'b00, 0);
		run(form_cmp_general, 1'b1, 8'h49, 1'b0, 5'h12, 5'h13, 2'b00, 0);
		run(form_cmp_general, 1'b0, 8'h00, 1'b0, 5'h04, 5'h0e, 2'b00, 0);
		run(form_decimal_add_with_carry_op, 1'b0, 8'h00, 1'b0, 5'h00, 5'h0f, 2'b00, 0);
		run(form_cmp_general, 1'b0, 8'h00, 1'b0, 5'h12, 5'h02, 2'b00, 0);
		// an illegal long form followed at once by a legal one
		run(form_cmp_long, 1'b0, 8'h00, 1'b0, 5'h10, 5'h12, 2'b00, 0);
		run(form_cmp_short_imm, 1'b0, 8'h00, 1'b0, 5'h12, 5'h12, 2'b00, 0);
		for (int i = 0; i < 600; i++) begin
			r = lfsr(r);
			f = op_form_t'(r[18:16]);
			pb = (r[2:0] == 3'h4) ? 8'h09 : (r[2:0] == 3'h5) ? 8'h41 : (r[2:0] == 3'h6) ? 8'h49 : r[15:8];
			sf = r[24:20];
			df = r[29:25];
			// unused fields held legal: their decode is not defined for these forms
			if (f inside {form_cmp_short_imm, form_cmp_short_src, form_cmp_ext_imm, form_decimal_add_with_carry_op_imm}) sf = 5'h12;
			if (f inside {form_cmp_short_imm, form_cmp_short_src}) df = 5'h12;
			run(f, r[2], pb, r[19], sf, df, r[31:30], (r[5:4] == 2'h3) ? 2 : 0);
		end
		fetch.idle();
		repeat (20) @(negedge clock);
		`CHK(exp_q.size(), 0)
		test_done();
	end
	initial begin
		#400000;
		error_cnt++;
		$display("[ERR] %0t watchdog expired", $time);
		test_done();
	end
endmodule
`default_nettype wire
